/* File: include/pep_pkg.sv */
// Purpose: Shared constants for the parallel EEPROM host controller
// Assumes: 50 MHz system clock, 32K x 8 device with 128-byte pages
// Notes:   Times are kept in their own unit; cycle counts derive from them

package pep_pkg;

	// ----------------------------------------------------------------
	// Geometry
	// ----------------------------------------------------------------
	localparam int ADDR_W      = 15;
	localparam int DATA_W      = 8;
	localparam int OFFS_W      = 7;   // Byte within page, bits 0..6
	localparam int PAGE_W      = 8;   // Page number, bits 7..14
	localparam int PAGE_BYTES  = 128;
	localparam int TOGGLE_BIT  = 6;
	localparam int TMR_W       = 20;

	// ----------------------------------------------------------------
	// Times in their own units
	// ----------------------------------------------------------------
	localparam int CLK_MHZ       = 50;
	localparam int T_LOCKOUT_MS  = 10;   // Longest powerup_write_lockout
	localparam int T_BLC_US      = 100;  // Longest byte_load_interval
	localparam int T_WC_MS       = 5;    // Longest self-timed write cycle
	localparam int T_WP_NS       = 100;  // Least write_strobe_width
	localparam int T_ACC_NS      = 150;  // Longest read access
	localparam int T_AH_NS       = 50;   // Least address hold after strobe
	localparam int T_HZ_NS       = 50;   // Longest output float time
	localparam int SYNC_STAGES   = 2;

	// ----------------------------------------------------------------
	// Cycle counts, least times rounded up
	// ----------------------------------------------------------------
	localparam int LOCKOUT_CYC = T_LOCKOUT_MS * CLK_MHZ * 1000;
	localparam int BLC_CYC     = T_BLC_US * CLK_MHZ + 1;  // Strictly past the limit
	localparam int WC_CYC      = 2 * T_WC_MS * CLK_MHZ * 1000; // Poll guard, twice the limit
	localparam int WP_CYC      = (T_WP_NS * CLK_MHZ + 999) / 1000;
	localparam int ACC_CYC     = (T_ACC_NS * CLK_MHZ + 999) / 1000 + SYNC_STAGES + 1;
	localparam int AH_CYC      = (T_AH_NS * CLK_MHZ + 999) / 1000;
	localparam int HZ_CYC      = (T_HZ_NS * CLK_MHZ + 999) / 1000;

	// ----------------------------------------------------------------
	// Commands and states
	// ----------------------------------------------------------------
	typedef enum logic [0:0] {
		PEP_CMD_READ   = 1'b0,
		PEP_CMD_COMMIT = 1'b1
	} pep_cmd_t;

	typedef enum logic [3:0] {
		PEP_ST_LOCK  = 4'b0000,
		PEP_ST_IDLE  = 4'b0001,
		PEP_ST_READ  = 4'b0010,
		PEP_ST_REC   = 4'b0011,
		PEP_ST_SCAN  = 4'b0100,
		PEP_ST_SETUP = 4'b0101,
		PEP_ST_PULSE = 4'b0110,
		PEP_ST_HOLD  = 4'b0111,
		PEP_ST_BLC   = 4'b1000,
		PEP_ST_POLL  = 4'b1001,
		PEP_ST_CHK   = 4'b1010
	} pep_state_t;

endpackage

/* File: hdl/pep_mem.sv */
// Purpose: Small page buffer memory with registered read data
// Assumes: One write and one read port on a single clock
// Notes:   Read data appear one enabled cycle after the read strobe
`timescale 1ns/1ps

module pep_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 128,
	parameter int AW    = 7
) (
	// Clock
	input  wire logic             clk,
	input  wire logic             clk_en,
	// Write port
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	// Read port
	input  wire logic             rd_en,
	input  wire logic [AW-1:0]    rd_addr,
	output logic      [WIDTH-1:0] rd_data
);

	initial begin
		if (DEPTH > (1 << AW) || DEPTH < 1) begin
			$error("pep_mem depth does not fit address width");
		end
	end

	logic [WIDTH-1:0] mem_r [DEPTH];

	// ----------------------------------------------------------------
	// Storage; contents need no reset, a mask tracks validity
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (clk_en) begin
			if (wr_en) begin
				mem_r[wr_addr] <= wr_data;
			end
			if (rd_en) begin
				rd_data <= mem_r[rd_addr];
			end
		end
	end

endmodule

/* File: hdl/pep_host.sv */
// Purpose: Host controller driving a parallel EEPROM through its pins
// Assumes: Device pins are asynchronous; data pins return through a synchroniser
// Notes:   Page bytes are gathered locally, then loaded back to back and polled
`timescale 1ns/1ps

module pep_host #(
	parameter int LOCK_CYC = pep_pkg::LOCKOUT_CYC,
	parameter int BLC_CYC  = pep_pkg::BLC_CYC,
	parameter int WC_CYC   = pep_pkg::WC_CYC
) (
	// Clock and reset
	input  wire logic                       clk,
	input  wire logic                       rst_b,
	input  wire logic                       clk_en,
	// Page buffer fill
	input  wire logic                       buf_wr_en,
	input  wire logic [pep_pkg::OFFS_W-1:0] buf_wr_offset,
	input  wire logic [pep_pkg::DATA_W-1:0] buf_wr_data,
	output logic                            buf_ready,
	// Command port
	input  wire logic                       cmd_valid,
	input  wire pep_pkg::pep_cmd_t          cmd_kind,
	input  wire logic [pep_pkg::ADDR_W-1:0] cmd_addr,
	output logic                            cmd_ready,
	output logic                            rsp_valid,
	output logic [pep_pkg::DATA_W-1:0]      rsp_data,
	output logic                            rsp_timeout,
	output logic                            busy,
	// Device pins
	output logic [pep_pkg::ADDR_W-1:0]      address_bus,
	output logic                            chip_sel_n,
	output logic                            out_en_n,
	output logic                            wr_strobe_n,
	output logic [pep_pkg::DATA_W-1:0]      data_pins_o,
	output logic                            data_pins_oe,
	input  wire logic [pep_pkg::DATA_W-1:0] data_pins_i
);

	localparam int TW = pep_pkg::TMR_W;

	initial begin
		if (LOCK_CYC < 1 || BLC_CYC < 1 || WC_CYC < 1 ||
		    LOCK_CYC >= (1 << TW) || BLC_CYC >= (1 << TW) || WC_CYC >= (1 << TW)) begin
			$error("pep_host cycle count out of timer range");
		end
	end

	function automatic logic [TW-1:0] cyc(input int n);
		cyc = n[TW-1:0];
	endfunction

	// ----------------------------------------------------------------
	// Data pin synchroniser
	// ----------------------------------------------------------------
	logic [pep_pkg::DATA_W-1:0] din_m_r;
	logic [pep_pkg::DATA_W-1:0] din_s_r;

	// Two stages; only the second is read by the controller
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			din_m_r <= '0;
			din_s_r <= '0;
		end else if (clk_en) begin
			din_m_r <= data_pins_i;
			din_s_r <= din_m_r;
		end
	end

	// ----------------------------------------------------------------
	// Controller state
	// ----------------------------------------------------------------
	pep_pkg::pep_state_t st_r, st_nxt;
	logic [TW-1:0]                    tmr_r, tmr_nxt;
	logic [TW-1:0]                    wdog_r, wdog_nxt;
	logic [pep_pkg::OFFS_W:0]         idx_r, idx_nxt;
	logic [pep_pkg::PAGE_BYTES-1:0]   mask_r, mask_nxt;
	logic [pep_pkg::PAGE_W-1:0]       page_r, page_nxt;
	logic [pep_pkg::ADDR_W-1:0]       last_r, last_nxt;
	logic [pep_pkg::DATA_W-1:0]       prev_r, prev_nxt;
	logic                             have_prev_r, have_prev_nxt;
	logic                             any_r, any_nxt;
	logic                             poll_r, poll_nxt;
	logic [pep_pkg::ADDR_W-1:0]       addr_r, addr_nxt;
	logic                             cs_n_r, cs_n_nxt;
	logic                             oe_n_r, oe_n_nxt;
	logic                             we_n_r, we_n_nxt;
	logic [pep_pkg::DATA_W-1:0]       dq_r, dq_nxt;
	logic                             dq_oe_r, dq_oe_nxt;
	logic                             rsp_v_r, rsp_v_nxt;
	logic [pep_pkg::DATA_W-1:0]       rsp_d_r, rsp_d_nxt;
	logic                             rsp_to_r, rsp_to_nxt;
	logic                             crdy_r, crdy_nxt;
	logic                             brdy_r, brdy_nxt;
	logic                             busy_r, busy_nxt;
	logic                             mem_rd;
	logic [pep_pkg::DATA_W-1:0]       mem_q;
	logic                             buf_take;

	assign buf_take = buf_wr_en && brdy_r;

	// ----------------------------------------------------------------
	// Next-state logic
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt        = st_r;
		tmr_nxt       = (tmr_r != '0) ? tmr_r - 1'b1 : tmr_r;
		wdog_nxt      = (wdog_r != '0) ? wdog_r - 1'b1 : wdog_r;
		idx_nxt       = idx_r;
		mask_nxt      = mask_r;
		page_nxt      = page_r;
		last_nxt      = last_r;
		prev_nxt      = prev_r;
		have_prev_nxt = have_prev_r;
		any_nxt       = any_r;
		poll_nxt      = poll_r;
		addr_nxt      = addr_r;
		cs_n_nxt      = cs_n_r;
		oe_n_nxt      = oe_n_r;
		we_n_nxt      = we_n_r;
		dq_nxt        = dq_r;
		dq_oe_nxt     = dq_oe_r;
		rsp_v_nxt     = 1'b0;
		rsp_d_nxt     = rsp_d_r;
		rsp_to_nxt    = rsp_to_r;
		crdy_nxt      = 1'b0;
		brdy_nxt      = 1'b0;
		mem_rd        = 1'b0;
		// Mark each byte offset placed in the page buffer
		if (buf_take) begin
			mask_nxt[buf_wr_offset] = 1'b1;
		end
		case (st_r)
			pep_pkg::PEP_ST_LOCK: begin
				// No pin activity until the device accepts writes
				if (tmr_r == '0) begin
					st_nxt   = pep_pkg::PEP_ST_IDLE;
					crdy_nxt = 1'b1;
					brdy_nxt = 1'b1;
				end
			end
			pep_pkg::PEP_ST_IDLE: begin
				crdy_nxt = 1'b1;
				brdy_nxt = 1'b1;
				if (cmd_valid && crdy_r) begin
					crdy_nxt = 1'b0;
					brdy_nxt = 1'b0;
					if (cmd_kind == pep_pkg::PEP_CMD_READ) begin
						// Write strobe stays high; select and output low
						addr_nxt = cmd_addr;
						cs_n_nxt = 1'b0;
						oe_n_nxt = 1'b0;
						poll_nxt = 1'b0;
						tmr_nxt  = cyc(pep_pkg::ACC_CYC);
						st_nxt   = pep_pkg::PEP_ST_READ;
					end else begin
						page_nxt = cmd_addr[pep_pkg::ADDR_W-1:pep_pkg::OFFS_W];
						idx_nxt  = '0;
						any_nxt  = 1'b0;
						st_nxt   = pep_pkg::PEP_ST_SCAN;
					end
				end
			end
			pep_pkg::PEP_ST_READ: begin
				if (tmr_r == '0) begin
					// Raising both lets the device float its outputs
					cs_n_nxt  = 1'b1;
					oe_n_nxt  = 1'b1;
					rsp_v_nxt = 1'b1;
					rsp_d_nxt = din_s_r;
					rsp_to_nxt = 1'b0;
					tmr_nxt   = cyc(pep_pkg::HZ_CYC);
					st_nxt    = pep_pkg::PEP_ST_REC;
				end
			end
			pep_pkg::PEP_ST_REC: begin
				// Wait out the float time before anyone drives the bus
				if (tmr_r == '0) begin
					if (poll_r) begin
						cs_n_nxt = 1'b0;
						oe_n_nxt = 1'b0;
						tmr_nxt  = cyc(pep_pkg::ACC_CYC);
						st_nxt   = pep_pkg::PEP_ST_POLL;
					end else begin
						crdy_nxt = 1'b1;
						brdy_nxt = 1'b1;
						st_nxt   = pep_pkg::PEP_ST_IDLE;
					end
				end
			end
			pep_pkg::PEP_ST_SCAN: begin
				// Only offsets loaded into the buffer are sent
				if (idx_r[pep_pkg::OFFS_W]) begin
					if (any_r) begin
						tmr_nxt = cyc(BLC_CYC);
						st_nxt  = pep_pkg::PEP_ST_BLC;
					end else begin
						rsp_v_nxt = 1'b1;
						rsp_to_nxt = 1'b0; // Stale timeout must not leak into an empty commit
						st_nxt    = pep_pkg::PEP_ST_REC;
						tmr_nxt   = '0;
					end
				end else if (mask_r[idx_r[pep_pkg::OFFS_W-1:0]]) begin
					mem_rd   = 1'b1;
					mask_nxt[idx_r[pep_pkg::OFFS_W-1:0]] = 1'b0;
					addr_nxt = {page_r, idx_r[pep_pkg::OFFS_W-1:0]};
					st_nxt   = pep_pkg::PEP_ST_SETUP;
				end else begin
					idx_nxt = idx_r + 1'b1;
				end
			end
			pep_pkg::PEP_ST_SETUP: begin
				// Output enable held high for the whole load
				cs_n_nxt  = 1'b0;
				oe_n_nxt  = 1'b1;
				dq_nxt    = mem_q;
				dq_oe_nxt = 1'b1;
				last_nxt  = addr_r;
				prev_nxt  = mem_q;
				any_nxt   = 1'b1;
				tmr_nxt   = cyc(pep_pkg::WP_CYC);
				st_nxt    = pep_pkg::PEP_ST_PULSE;
			end
			pep_pkg::PEP_ST_PULSE: begin
				// Strobe falls last, so it latches the address
				we_n_nxt = 1'b0;
				if (tmr_r == '0) begin
					// Full-width pulse, far above the noise filter
					we_n_nxt = 1'b1;
					tmr_nxt  = cyc(pep_pkg::AH_CYC);
					st_nxt   = pep_pkg::PEP_ST_HOLD;
				end
			end
			pep_pkg::PEP_ST_HOLD: begin
				// Data and address held past the rising strobe edge
				if (tmr_r == '0) begin
					cs_n_nxt  = 1'b1;
					dq_oe_nxt = 1'b0;
					idx_nxt   = idx_r + 1'b1;
					// Next load follows within a few hundred cycles
					st_nxt    = pep_pkg::PEP_ST_SCAN;
				end
			end
			pep_pkg::PEP_ST_BLC: begin
				// Strobe stays high until the load timer has expired
				if (tmr_r == '0) begin
					cs_n_nxt      = 1'b0;
					oe_n_nxt      = 1'b0;
					addr_nxt      = last_r;
					have_prev_nxt = 1'b0;
					poll_nxt      = 1'b1;
					wdog_nxt      = cyc(WC_CYC);
					tmr_nxt       = cyc(pep_pkg::ACC_CYC);
					st_nxt        = pep_pkg::PEP_ST_POLL;
				end
			end
			pep_pkg::PEP_ST_POLL: begin
				if (tmr_r == '0) begin
					cs_n_nxt = 1'b1;
					oe_n_nxt = 1'b1;
					st_nxt   = pep_pkg::PEP_ST_CHK;
				end
			end
			pep_pkg::PEP_ST_CHK: begin
				// Stable toggle bit and true bit 7 mean programming ended
				tmr_nxt       = cyc(pep_pkg::HZ_CYC);
				st_nxt        = pep_pkg::PEP_ST_REC;
				have_prev_nxt = 1'b1;
				prev_nxt      = din_s_r;
				if (have_prev_r && (prev_r[pep_pkg::TOGGLE_BIT] == din_s_r[pep_pkg::TOGGLE_BIT]) &&
				    (din_s_r[pep_pkg::DATA_W-1] == mem_q[pep_pkg::DATA_W-1])) begin
					poll_nxt   = 1'b0;
					rsp_v_nxt  = 1'b1;
					rsp_d_nxt  = din_s_r;
					rsp_to_nxt = 1'b0;
				end else if (wdog_r == '0) begin
					poll_nxt   = 1'b0;
					rsp_v_nxt  = 1'b1;
					rsp_d_nxt  = din_s_r;
					rsp_to_nxt = 1'b1;
				end
			end
			default: begin
				st_nxt = pep_pkg::PEP_ST_IDLE;
			end
		endcase
		// Busy is the inverse of the ready flag, registered alongside it
		busy_nxt = ~crdy_nxt;
	end

	// ----------------------------------------------------------------
	// Registers; no new load is issued until polling ends
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st_r        <= pep_pkg::PEP_ST_LOCK;
			tmr_r       <= cyc(LOCK_CYC);
			wdog_r      <= '0;
			idx_r       <= '0;
			mask_r      <= '0;
			page_r      <= '0;
			last_r      <= '0;
			prev_r      <= '0;
			have_prev_r <= 1'b0;
			any_r       <= 1'b0;
			poll_r      <= 1'b0;
			addr_r      <= '0;
			cs_n_r      <= 1'b1;
			oe_n_r      <= 1'b1;
			we_n_r      <= 1'b1;
			dq_r        <= '0;
			dq_oe_r     <= 1'b0;
			rsp_v_r     <= 1'b0;
			rsp_d_r     <= '0;
			rsp_to_r    <= 1'b0;
			crdy_r      <= 1'b0;
			brdy_r      <= 1'b0;
			busy_r      <= 1'b1;
		end else if (clk_en) begin
			st_r        <= st_nxt;
			tmr_r       <= tmr_nxt;
			wdog_r      <= wdog_nxt;
			idx_r       <= idx_nxt;
			mask_r      <= mask_nxt;
			page_r      <= page_nxt;
			last_r      <= last_nxt;
			prev_r      <= prev_nxt;
			have_prev_r <= have_prev_nxt;
			any_r       <= any_nxt;
			poll_r      <= poll_nxt;
			addr_r      <= addr_nxt;
			cs_n_r      <= cs_n_nxt;
			oe_n_r      <= oe_n_nxt;
			we_n_r      <= we_n_nxt;
			dq_r        <= dq_nxt;
			dq_oe_r     <= dq_oe_nxt;
			rsp_v_r     <= rsp_v_nxt;
			rsp_d_r     <= rsp_d_nxt;
			rsp_to_r    <= rsp_to_nxt;
			crdy_r      <= crdy_nxt;
			brdy_r      <= brdy_nxt;
			busy_r      <= busy_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Page buffer; read port also recalls the last byte for polling
	// ----------------------------------------------------------------
	pep_mem #(
		.WIDTH (pep_pkg::DATA_W),
		.DEPTH (pep_pkg::PAGE_BYTES),
		.AW    (pep_pkg::OFFS_W)
	) u_buf (
		.clk     (clk),
		.clk_en  (clk_en),
		.wr_en   (buf_take),
		.wr_addr (buf_wr_offset),
		.wr_data (buf_wr_data),
		.rd_en   (mem_rd),
		.rd_addr (idx_r[pep_pkg::OFFS_W-1:0]),
		.rd_data (mem_q)
	);

	// ----------------------------------------------------------------
	// Outputs, all straight from flip-flops
	// ----------------------------------------------------------------
	assign address_bus  = addr_r;
	assign chip_sel_n   = cs_n_r;
	assign out_en_n     = oe_n_r;
	assign wr_strobe_n  = we_n_r;
	assign data_pins_o  = dq_r;
	assign data_pins_oe = dq_oe_r;
	assign rsp_valid    = rsp_v_r;
	assign rsp_data     = rsp_d_r;
	assign rsp_timeout  = rsp_to_r;
	assign cmd_ready    = crdy_r;
	assign buf_ready    = brdy_r;
	assign busy         = busy_r;

endmodule

/* File: verif/pep_host_props.sv */
// Purpose: Port checks for the parallel EEPROM host controller
// Assumes: One clock, synchronous active-low reset
// Notes:   Saturating counters stand in for long waits
`timescale 1ns/1ps
module pep_host_props #(
	parameter int LOCK_CYC = 20,
	parameter int BLC_CYC  = 50
) (
	// Clock and reset
	input wire logic                       clk,
	input wire logic                       rst_b,
	input wire logic                       clk_en,
	// Command port
	input wire logic                       cmd_valid,
	input wire pep_pkg::pep_cmd_t          cmd_kind,
	input wire logic                       cmd_ready,
	input wire logic                       rsp_valid,
	// Device pins
	input wire logic [pep_pkg::ADDR_W-1:0] address_bus,
	input wire logic                       chip_sel_n,
	input wire logic                       out_en_n,
	input wire logic                       wr_strobe_n,
	input wire logic [pep_pkg::DATA_W-1:0] data_pins_o,
	input wire logic                       data_pins_oe
);
	// ----------------------------------------------------------------
	// Elapsed-cycle helpers
	// ----------------------------------------------------------------
	int   lock_cnt;
	int   rise_cnt;
	int   fall_cnt;
	logic page_open;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// Counts saturate so long idle spells never wrap
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			lock_cnt  <= 0;
			rise_cnt  <= BLC_CYC;
			fall_cnt  <= BLC_CYC;
			page_open <= 1'b0;
		end else if (clk_en) begin
			lock_cnt  <= (lock_cnt < LOCK_CYC) ? lock_cnt + 1 : lock_cnt;
			rise_cnt  <= $rose(wr_strobe_n) ? 0 : (rise_cnt < BLC_CYC ? rise_cnt + 1 : rise_cnt);
			fall_cnt  <= $fell(wr_strobe_n) ? 0 : (fall_cnt < BLC_CYC ? fall_cnt + 1 : fall_cnt);
			page_open <= !out_en_n ? 1'b0 : ($fell(wr_strobe_n) ? 1'b1 : page_open);
		end
	end
	AST_LOCKOUT_WRITE: assert property (!wr_strobe_n |-> lock_cnt >= LOCK_CYC)
		else $error("write strobe during power-up lockout");
	AST_WRITE_STROBES: assert property (!wr_strobe_n |-> !chip_sel_n && out_en_n && data_pins_oe)
		else $error("write strobe without select, data or with output enable");
	AST_READ_STROBES: assert property (!out_en_n |-> !chip_sel_n && wr_strobe_n && !data_pins_oe)
		else $error("read strobes in a bad combination");
	AST_STROBE_WIDTH: assert property ($fell(wr_strobe_n) |-> (!wr_strobe_n && $stable(address_bus))[*5])
		else $error("write strobe too short or address moved");
	AST_DATA_AT_RISE: assert property ($rose(wr_strobe_n) |-> data_pins_oe && !chip_sel_n && $stable(data_pins_o))
		else $error("data not held at strobe rise");
	AST_LOAD_GAP: assert property ($fell(wr_strobe_n) && page_open |-> fall_cnt inside {[4:BLC_CYC-1]})
		else $error("byte loads spaced outside the load interval");
	AST_PROGRAM_WAIT: assert property ($fell(out_en_n) |-> rise_cnt >= BLC_CYC - 1)
		else $error("poll read before the load timer ran out");
	AST_READ_TIMING: assert property (clk_en && cmd_valid && cmd_ready && cmd_kind == pep_pkg::PEP_CMD_READ
		|=> ##1 (!out_en_n && $stable(address_bus))[*7] ##[1:8] rsp_valid)
		else $error("read cycle shape or answer time wrong");
	AST_STANDBY_FLOAT: assert property (chip_sel_n |-> !data_pins_oe && wr_strobe_n)
		else $error("host drives data while device deselected");
endmodule
bind pep_host pep_host_props #(.LOCK_CYC(LOCK_CYC), .BLC_CYC(BLC_CYC)) u_props (
	.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
	.cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .address_bus(address_bus), .chip_sel_n(chip_sel_n),
	.out_en_n(out_en_n), .wr_strobe_n(wr_strobe_n), .data_pins_o(data_pins_o), .data_pins_oe(data_pins_oe)
);

/* File: verif/pep_dev_model.sv */
// Purpose: Behavioural parallel EEPROM answering the host bench
// Assumes: Pin level only, times in ns
// Notes:   Released data pins show the inverse of the last value
`timescale 1ns/1ps
module pep_dev_model #(
	parameter int LOCK_NS = 300,
	parameter int BLC_NS  = 3500
) (
	// Control pins
	input wire logic [14:0] address_bus,
	input wire logic        chip_sel_n,
	input wire logic        out_en_n,
	input wire logic        wr_strobe_n,
	// Data pins
	input wire logic [7:0]  dq_in,
	output logic     [7:0]  dq_out,
	output logic            dq_drive
);
	// ----------------------------------------------------------------
	// Array, page buffer and write state
	// ----------------------------------------------------------------
	logic [7:0]   mem [0:32767];
	logic [7:0]   pbuf [0:127];
	logic [127:0] loaded;
	logic [14:0]  a_lat;
	logic [14:0]  last_a;
	logic [7:0]   page;
	logic [7:0]   last_d;
	logic         busy;
	logic         tgl;
	logic         locked;
	realtime      t_fall;
	realtime      t_rise;
	int           wc_ns;
	wire          wr_act = !chip_sel_n && !wr_strobe_n && out_en_n;
	initial begin
		foreach (mem[i]) mem[i] = i[7:0];
		loaded = '0;
		busy = 1'b0;
		tgl = 1'b0;
		dq_drive = 1'b0;
		dq_out = 8'h00;
		wc_ns = 2000;
		t_rise = 0;
		locked = 1'b1;
		#(LOCK_NS) locked = 1'b0;
	end
	// Address on the later fall, data on the earlier rise; glitches dropped
	always @(wr_act) begin
		if (wr_act) begin
			a_lat = address_bus;
			t_fall = $realtime;
		end else if (!busy && !locked && $realtime - t_fall >= 20) begin
			pbuf[a_lat[6:0]] = dq_in;
			loaded[a_lat[6:0]] = 1'b1;
			page = a_lat[14:7];
			last_a = a_lat;
			last_d = dq_in;
		end
	end
	// Load timer restarts on each rise; a low strobe holds it off
	always @(posedge wr_strobe_n) t_rise = $realtime;
	always #10 begin
		if (loaded != '0 && wr_strobe_n && $realtime - t_rise >= BLC_NS) begin
			busy = 1'b1;
			#(wc_ns);
			for (int i = 0; i < 128; i++)
				if (loaded[i]) mem[{page, i[6:0]}] = pbuf[i];
			loaded = '0;
			busy = 1'b0;
		end
	end
	// Read drive; each fresh read flips the toggle bit while busy
	always @(address_bus, chip_sel_n, out_en_n, wr_strobe_n, busy) begin
		if (!chip_sel_n && !out_en_n && wr_strobe_n) begin
			if (!dq_drive)
				tgl = ~tgl;
			dq_drive = 1'b1;
			dq_out = mem[address_bus];
			if (busy)
				dq_out[6] = tgl;
			if (busy && address_bus == last_a)
				dq_out[7] = ~last_d[7];
		end else if (dq_drive) begin
			dq_drive = 1'b0;
			dq_out = ~dq_out;
		end
	end
endmodule

/* File: verif/tb_pep_host.sv */
// Purpose: Self-checking bench for the parallel EEPROM host
// Assumes: Behavioural device on the pins, inputs driven at falling edge
// Notes:   Short lockout, load timer and watchdog counts
`timescale 1ns/1ps
module tb_pep_host;
	// ----------------------------------------------------------------
	// Signals and instances
	// ----------------------------------------------------------------
	logic              clk = 1'b0;
	logic              rst_b = 1'b0;
	logic              clk_en = 1'b1;
	logic              buf_wr_en = 1'b0;
	logic [6:0]        buf_wr_offset = 7'h00;
	logic [7:0]        buf_wr_data = 8'h00;
	logic              cmd_valid = 1'b0;
	pep_pkg::pep_cmd_t cmd_kind = pep_pkg::PEP_CMD_READ;
	logic [14:0]       cmd_addr = 15'h0000;
	logic              buf_ready, cmd_ready, rsp_valid, rsp_timeout, busy;
	logic [7:0]        rsp_data, data_pins_o, dev_dq, rd;
	logic [14:0]       address_bus;
	logic              chip_sel_n, out_en_n, wr_strobe_n, data_pins_oe, dev_drv, to;
	wire  [7:0]        dq_wire = data_pins_oe ? data_pins_o : dev_dq;
	logic [7:0]        shadow [0:32767];
	int                fails = 0, comparisons = 0, cycles = 0, wr_falls = 0;
	always #10 clk = ~clk;
	pep_host #(.LOCK_CYC(20), .BLC_CYC(200), .WC_CYC(400)) u_dut (
		.clk(clk), .rst_b(rst_b), .clk_en(clk_en), .buf_wr_en(buf_wr_en), .buf_wr_offset(buf_wr_offset),
		.buf_wr_data(buf_wr_data), .buf_ready(buf_ready), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
		.cmd_addr(cmd_addr), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
		.rsp_timeout(rsp_timeout), .busy(busy), .address_bus(address_bus), .chip_sel_n(chip_sel_n),
		.out_en_n(out_en_n), .wr_strobe_n(wr_strobe_n), .data_pins_o(data_pins_o),
		.data_pins_oe(data_pins_oe), .data_pins_i(dq_wire));
	pep_dev_model #(.LOCK_NS(300), .BLC_NS(3500)) u_dev (
		.address_bus(address_bus), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
		.wr_strobe_n(wr_strobe_n), .dq_in(dq_wire), .dq_out(dev_dq), .dq_drive(dev_drv));
	// Hang guard; both sides driving the data pins is a fault too
	always @(negedge clk) begin
		cycles++;
		if (data_pins_oe && dev_drv) begin
			fails++;
			$display("CHECK FAILED data_pins_contention expected 0 seen 1");
		end
		if (cycles == 30000) begin
			fails++;
			$display("CHECK FAILED run_length expected finished seen hung");
			complete_run();
		end
	end
	always @(negedge wr_strobe_n) wr_falls++;
	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic fill(input logic [6:0] off, input logic [7:0] d);
		while (buf_ready !== 1'b1)
			@(negedge clk);
		buf_wr_en = 1'b1;
		buf_wr_offset = off;
		buf_wr_data = d;
		@(negedge clk);
		buf_wr_en = 1'b0;
		@(negedge clk);
	endtask
	task automatic cmd(input pep_pkg::pep_cmd_t k, input logic [14:0] a);
		while (cmd_ready !== 1'b1)
			@(negedge clk);
		cmd_kind = k;
		cmd_addr = a;
		cmd_valid = 1'b1;
		@(negedge clk);
		cmd_valid = 1'b0;
		check("busy_taken", 8'h01, {7'h00, busy});
		while (rsp_valid !== 1'b1)
			@(negedge clk);
		rd = rsp_data;
		to = rsp_timeout;
		@(negedge clk);
	endtask
	task automatic check_rd(input logic [14:0] a);
		cmd(pep_pkg::PEP_CMD_READ, a);
		check("read_data", shadow[a], rd);
	endtask
	task automatic commit(input logic [14:0] a, input logic [7:0] last);
		cmd(pep_pkg::PEP_CMD_COMMIT, a);
		check("commit_timeout", 8'h00, {7'h00, to});
		check("commit_final", last, rd);
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_lockout();
		int n;
		n = 0;
		rst_b = 1'b0;
		repeat (12) @(negedge clk);
		rst_b = 1'b1;
		// Frozen clock enable must hold the lockout count
		clk_en = 1'b0;
		repeat (10) @(negedge clk);
		clk_en = 1'b1;
		while (cmd_ready !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		check("lockout_wait", 8'h01, {7'h00, n >= 20 && n <= 23});
		check("busy_idle", 8'h00, {7'h00, busy});
	endtask
	// Page 5 byte, commit address with junk low bits
	task automatic t_byte();
		fill(7'h09, 8'h3c);
		shadow[15'h0289] = 8'h3c;
		commit(15'h02ff, 8'h3c);
		check_rd(15'h0289);
		check_rd(15'h0288);
	endtask
	// Page 0x7f, all 128 bytes loaded in descending order
	task automatic t_full();
		for (int i = 127; i >= 0; i--) begin
			fill(i[6:0], i[7:0] ^ 8'ha5);
			shadow[{8'h7f, i[6:0]}] = i[7:0] ^ 8'ha5;
		end
		commit(15'h3f80, 8'hda);
		check_rd(15'h3f80);
		check_rd(15'h3fc0);
		check_rd(15'h3fff);
	endtask
	// Sparse page with an overwrite; gaps stay untouched
	task automatic t_sparse();
		fill(7'h00, 8'h11);
		fill(7'h28, 8'h22);
		fill(7'h7f, 8'h33);
		fill(7'h28, 8'h44);
		shadow[15'h0000] = 8'h11;
		shadow[15'h0028] = 8'h44;
		shadow[15'h007f] = 8'h33;
		commit(15'h0000, 8'h33);
		for (int j = 0; j < 128; j += 20)
			check_rd(15'h0000 + j[14:0]);
		check_rd(15'h007f);
	endtask
	task automatic t_empty();
		int n;
		n = wr_falls;
		cmd(pep_pkg::PEP_CMD_COMMIT, 15'h1200);
		check("empty_falls", n[7:0], wr_falls[7:0]);
		check("empty_timeout", 8'h00, {7'h00, to});
	endtask
	// Slow device outlasts the watchdog, then true data returns
	task automatic t_slow();
		int n;
		n = 0;
		u_dev.wc_ns = 20000;
		fill(7'h05, 8'h80);
		shadow[15'h4005] = 8'h80;
		cmd(pep_pkg::PEP_CMD_COMMIT, 15'h4000);
		check("slow_timeout", 8'h01, {7'h00, to});
		while (u_dev.busy && n < 2000) begin
			@(negedge clk);
			n++;
		end
		u_dev.wc_ns = 2000;
		check_rd(15'h4005);
	endtask
	initial begin
		for (int i = 0; i < 32768; i++)
			shadow[i] = i[7:0];
		t_lockout();
		check_rd(15'h7fff);
		check_rd(15'h0123);
		t_byte();
		t_full();
		t_sparse();
		t_empty();
		t_slow();
		t_lockout();
		check_rd(15'h3fc0);
		complete_run();
	end
endmodule
